// >>> include/dbac_pkg.sv
// Constants, types and helpers shared by the audio and test register bank
package dbac_pkg;

  localparam logic [7:0] OFS_ERROR_COUNT = 8'h25;
  localparam logic [7:0] OFS_HIGH_TIME   = 8'h26;
  localparam logic [7:0] OFS_LOW_TIME    = 8'h27;
  localparam logic [7:0] OFS_AUDIO       = 8'h28;

  localparam logic [7:0] RST_ERROR_COUNT = 8'h00;
  localparam logic [7:0] RST_HIGH_TIME   = 8'h83;
  localparam logic [7:0] RST_LOW_TIME    = 8'h84;
  localparam logic [7:0] RST_AUDIO       = 8'h00;

  localparam int unsigned AUD_HOLD_BIT = 7;
  localparam int unsigned AUD_AUX_BIT  = 3;
  localparam int unsigned AUD_OFF_BIT  = 2;
  localparam int unsigned AUD_SURR_BIT = 0;
  localparam logic [7:0]  AUD_WR_MASK  = 8'h8D;
  localparam logic [7:0]  AUD_FC_MASK  = 8'h0D;

  localparam logic [7:0] ERROR_MAX   = 8'hFF;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  // Target address on the serial control bus; arbitrary value
  localparam logic [6:0] TARGET_ADDR = 7'h2C;

  localparam int unsigned UNIT_NS = 50;
  localparam int unsigned CLK_NS  = 100;

  typedef enum {
    BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_PTR, BUS_ACK_PTR,
    BUS_WRITE, BUS_ACK_WRITE, BUS_READ, BUS_ACK_READ
  } dbac_bus_state_type;

  typedef enum {
    GEN_HIGH, GEN_LOW
  } dbac_gen_state_type;

  // Count of 50 ns units to clock cycles, rounded up, never below one
  function automatic logic [8:0] to_cycles(input logic [7:0] units);
    logic [15:0] ns;
    ns        = 16'(units) * 16'(UNIT_NS);
    to_cycles = 9'((ns + 16'(CLK_NS - 1)) / 16'(CLK_NS));
    if (to_cycles == 9'h000)
    begin
      to_cycles = 9'h001;
    end
  endfunction : to_cycles

endpackage : dbac_pkg

// >>> include/dbac_scl_if.sv
// Carrier between the register bank and its local clock-line generator
interface dbac_scl_if;
  logic       run;
  logic [8:0] high_cyc;
  logic [8:0] low_cyc;
  logic       scl_low;

  modport ctrl (output run, output high_cyc, output low_cyc, input scl_low);
  modport gen  (input run, input high_cyc, input low_cyc, output scl_low);
endinterface : dbac_scl_if

// >>> rtl/dbac_scl_gen.sv
// Clock-line generator for the device acting as master on its local bus
module dbac_scl_gen (
  input  wire logic clk_i,
  input  wire logic rst_i,
  dbac_scl_if.gen   bus
);

  dbac_pkg::dbac_gen_state_type st;
  dbac_pkg::dbac_gen_state_type next_st;
  logic [8:0]                   cnt;
  logic [8:0]                   next_cnt;

  always_comb
  begin
    next_st  = st;
    next_cnt = cnt + 9'h001;
    case (st)
      dbac_pkg::GEN_HIGH:
      begin
        if (!bus.run)
        begin
          next_cnt = 9'h000;
        end
        else if (cnt >= bus.high_cyc - 9'h001)
        begin
          next_st  = dbac_pkg::GEN_LOW;
          next_cnt = 9'h000;
        end
      end
      dbac_pkg::GEN_LOW:
      begin
        if (cnt >= bus.low_cyc - 9'h001)
        begin
          next_st  = dbac_pkg::GEN_HIGH;
          next_cnt = 9'h000;
        end
      end
      default:
      begin
        next_st  = dbac_pkg::GEN_HIGH;
        next_cnt = 9'h000;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st  <= dbac_pkg::GEN_HIGH;
      cnt <= 9'h000;
    end
    else
    begin
      st  <= next_st;
      cnt <= next_cnt;
    end
  end

  assign bus.scl_low = (st == dbac_pkg::GEN_LOW);

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_gen_high_width: assert property (
    (st == dbac_pkg::GEN_HIGH && next_st == dbac_pkg::GEN_LOW) |-> (cnt + 9'h001 >= bus.high_cyc))
    else $error("local clock high phase ended early");

  chk_gen_low_width: assert property (
    (st == dbac_pkg::GEN_LOW && next_st == dbac_pkg::GEN_HIGH) |-> (cnt + 9'h001 >= bus.low_cyc))
    else $error("local clock low phase ended early");

endmodule : dbac_scl_gen

// >>> rtl/dbac_regs.sv
// Self-test error count, local clock timing and audio path control registers
module dbac_regs (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       power_down_bar_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_drive_n_o,
  output logic            sda_drive_n_o,
  input  wire logic       local_master_run_i,
  output logic            local_scl_drive_n_o,
  input  wire logic       selftest_run_bit_i,
  input  wire logic       fc_error_i,
  input  wire logic       fc_load_i,
  input  wire logic [7:0] fc_data_i,
  input  wire logic       repeater_i,
  input  wire logic       inband_valid_i,
  input  wire logic       inband_surround_i,
  input  wire logic       frame_transport_i,
  input  wire logic [1:0] gpio_out_i,
  input  wire logic       aux_word_select_i,
  input  wire logic       aux_data_i,
  input  wire logic [3:0] i2s_data_i,
  output logic [1:0]      general_io_o,
  output logic [3:0]      i2s_data_o,
  output logic            surround_o,
  output logic            frame_transport_o
);

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] pin_raw;
  logic       scl_p;
  logic       sda_p;

  assign pin_raw = {power_down_bar_i, sda_i, scl_i};

  // Pins pass two flops; only the second stage is read anywhere
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_sync
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          sync1[g] <= 1'b1;
          sync2[g] <= 1'b1;
        end
        else
        begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_p <= sync2[0];
      sda_p <= sync2[1];
    end
  end

  logic scl_s, sda_s, pdb_s, start_ev, stop_ev, rise_ev, fall_ev;
  assign scl_s    = sync2[0];
  assign sda_s    = sync2[1];
  assign pdb_s    = sync2[2];
  assign start_ev = scl_s && scl_p && sda_p && !sda_s;
  assign stop_ev  = scl_s && scl_p && !sda_p && sda_s;
  assign rise_ev  = scl_s && !scl_p;
  assign fall_ev  = !scl_s && scl_p;

  logic [7:0] err_cnt, high_t, low_t, audio;
  logic [7:0] next_err_cnt, next_high_t, next_low_t, next_audio;
  logic       run_p, wr_en, next_wr_en;
  logic [7:0] wr_addr, next_wr_addr, wr_data, next_wr_data, rd_data;
  logic [8:0] low_cyc;

  assign low_cyc = dbac_pkg::to_cycles(low_t);

  dbac_pkg::dbac_bus_state_type st, next_st;
  logic [3:0] cnt, next_cnt;
  logic [7:0] shreg, next_shreg, ptr, next_ptr;
  logic [8:0] scnt, next_scnt;
  logic       rw, next_rw, next_sda_n;

  always_comb
  begin
    case (ptr)
      dbac_pkg::OFS_ERROR_COUNT: rd_data = err_cnt;
      dbac_pkg::OFS_HIGH_TIME:   rd_data = high_t;
      dbac_pkg::OFS_LOW_TIME:    rd_data = low_t;
      dbac_pkg::OFS_AUDIO:       rd_data = audio & dbac_pkg::AUD_WR_MASK;
      default:                   rd_data = 8'h00;
    endcase
  end

  always_comb
  begin
    next_st      = st;
    next_cnt     = cnt;
    next_shreg   = shreg;
    next_ptr     = ptr;
    next_rw      = rw;
    next_sda_n   = sda_drive_n_o;
    next_wr_en   = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_scnt    = (scnt == 9'h000) ? 9'h000 : scnt - 9'h001;
    if (stop_ev)
    begin
      next_st    = dbac_pkg::BUS_IDLE;
      next_sda_n = 1'b1;
    end
    else if (start_ev)
    begin
      next_st    = dbac_pkg::BUS_ADDR;
      next_cnt   = 4'h0;
      next_sda_n = 1'b1;
    end
    else
    begin
      case (st)
        dbac_pkg::BUS_IDLE:
        begin
          next_sda_n = 1'b1;
        end
        dbac_pkg::BUS_ADDR, dbac_pkg::BUS_PTR, dbac_pkg::BUS_WRITE:
        begin
          if (rise_ev)
          begin
            next_shreg = {shreg[6:0], sda_s};
            next_cnt   = cnt + 4'h1;
          end
          else if (fall_ev && cnt == dbac_pkg::BYTE_BITS)
          begin
            next_cnt   = 4'h0;
            next_sda_n = 1'b0;
            if (st == dbac_pkg::BUS_ADDR)
            begin
              next_rw = shreg[0];
              next_st = dbac_pkg::BUS_ACK_ADDR;
              if (shreg[7:1] != dbac_pkg::TARGET_ADDR)
              begin
                next_st    = dbac_pkg::BUS_IDLE;
                next_sda_n = 1'b1;
              end
            end
            else if (st == dbac_pkg::BUS_PTR)
            begin
              next_ptr = shreg;
              next_st  = dbac_pkg::BUS_ACK_PTR;
            end
            else
            begin
              next_wr_en   = 1'b1;
              next_wr_addr = ptr;
              next_wr_data = shreg;
              next_ptr     = ptr + 8'h01;
              next_st      = dbac_pkg::BUS_ACK_WRITE;
            end
          end
        end
        dbac_pkg::BUS_ACK_ADDR, dbac_pkg::BUS_ACK_PTR, dbac_pkg::BUS_ACK_WRITE,
        dbac_pkg::BUS_ACK_READ:
        begin
          if (st == dbac_pkg::BUS_ACK_READ && rise_ev && sda_s)
          begin
            next_st = dbac_pkg::BUS_IDLE;
          end
          else if (fall_ev)
          begin
            next_sda_n = 1'b1;
            next_st    = (st == dbac_pkg::BUS_ACK_ADDR) ? dbac_pkg::BUS_PTR
                                                        : dbac_pkg::BUS_WRITE;
            if (rw && (st == dbac_pkg::BUS_ACK_ADDR || st == dbac_pkg::BUS_ACK_READ))
            begin
              // First bit goes out while the clock is held low
              next_shreg = rd_data;
              next_sda_n = rd_data[7];
              next_scnt  = low_cyc;
              next_cnt   = 4'h0;
              next_st    = dbac_pkg::BUS_READ;
            end
          end
        end
        dbac_pkg::BUS_READ:
        begin
          if (rise_ev)
          begin
            next_cnt = cnt + 4'h1;
          end
          else if (fall_ev && cnt == dbac_pkg::BYTE_BITS)
          begin
            next_sda_n = 1'b1;
            next_cnt   = 4'h0;
            next_ptr   = ptr + 8'h01;
            next_st    = dbac_pkg::BUS_ACK_READ;
          end
          else if (fall_ev)
          begin
            next_shreg = {shreg[6:0], 1'b0};
            next_sda_n = shreg[6];
          end
        end
        default:
        begin
          next_st    = dbac_pkg::BUS_IDLE;
          next_sda_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st            <= dbac_pkg::BUS_IDLE;
      cnt           <= 4'h0;
      shreg         <= 8'h00;
      ptr           <= 8'h00;
      rw            <= 1'b0;
      scnt          <= 9'h000;
      wr_en         <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 8'h00;
      sda_drive_n_o <= 1'b1;
      scl_drive_n_o <= 1'b1;
    end
    else
    begin
      st            <= next_st;
      cnt           <= next_cnt;
      shreg         <= next_shreg;
      ptr           <= next_ptr;
      rw            <= next_rw;
      scnt          <= next_scnt;
      wr_en         <= next_wr_en;
      wr_addr       <= next_wr_addr;
      wr_data       <= next_wr_data;
      sda_drive_n_o <= next_sda_n;
      scl_drive_n_o <= (next_scnt == 9'h000);
    end
  end

  always_comb
  begin
    next_err_cnt = err_cnt;
    next_high_t  = high_t;
    next_low_t   = low_t;
    next_audio   = audio;
    if (selftest_run_bit_i && !run_p)
    begin
      next_err_cnt = dbac_pkg::RST_ERROR_COUNT;
    end
    else if (selftest_run_bit_i && fc_error_i && err_cnt != dbac_pkg::ERROR_MAX)
    begin
      next_err_cnt = err_cnt + 8'h01;
    end
    // Counting stops with the run bit, so the value then stands still
    if (fc_load_i && !audio[dbac_pkg::AUD_HOLD_BIT])
    begin
      next_audio = (audio & ~dbac_pkg::AUD_FC_MASK) | (fc_data_i & dbac_pkg::AUD_FC_MASK);
    end
    // A control-bus write lands after a same-cycle load and wins over it
    if (wr_en)
    begin
      case (wr_addr)
        dbac_pkg::OFS_HIGH_TIME: next_high_t = wr_data;
        dbac_pkg::OFS_LOW_TIME:  next_low_t  = wr_data;
        dbac_pkg::OFS_AUDIO:     next_audio  = wr_data & dbac_pkg::AUD_WR_MASK;
        default:                 next_audio  = next_audio;
      endcase
    end
    if (!pdb_s)
    begin
      next_err_cnt = dbac_pkg::RST_ERROR_COUNT;
      next_high_t  = dbac_pkg::RST_HIGH_TIME;
      next_low_t   = dbac_pkg::RST_LOW_TIME;
      next_audio   = dbac_pkg::RST_AUDIO;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      err_cnt <= dbac_pkg::RST_ERROR_COUNT;
      high_t  <= dbac_pkg::RST_HIGH_TIME;
      low_t   <= dbac_pkg::RST_LOW_TIME;
      audio   <= dbac_pkg::RST_AUDIO;
      run_p   <= 1'b0;
    end
    else
    begin
      err_cnt <= next_err_cnt;
      high_t  <= next_high_t;
      low_t   <= next_low_t;
      audio   <= next_audio;
      run_p   <= selftest_run_bit_i;
    end
  end

  logic next_surround;

  always_comb
  begin
    next_surround = audio[dbac_pkg::AUD_SURR_BIT];
    if (repeater_i && inband_valid_i)
    begin
      next_surround = inband_surround_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      general_io_o      <= 2'h0;
      i2s_data_o        <= 4'h0;
      surround_o        <= 1'b0;
      frame_transport_o <= 1'b0;
    end
    else
    begin
      general_io_o      <= audio[dbac_pkg::AUD_AUX_BIT] ? {aux_word_select_i, aux_data_i}
                                                        : gpio_out_i;
      i2s_data_o        <= audio[dbac_pkg::AUD_OFF_BIT] ? 4'h0 : i2s_data_i;
      surround_o        <= next_surround;
      frame_transport_o <= frame_transport_i && !next_surround;
    end
  end

  dbac_scl_if sif ();
  assign sif.run      = local_master_run_i;
  assign sif.high_cyc = dbac_pkg::to_cycles(high_t);
  assign sif.low_cyc  = low_cyc;

  dbac_scl_gen u_gen (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (sif.gen)
  );

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      local_scl_drive_n_o <= 1'b1;
    end
    else
    begin
      local_scl_drive_n_o <= !sif.scl_low;
    end
  end

  // Helper: length of the current clock stretch
  logic [8:0] hold_len;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hold_len <= 9'h000;
    end
    else
    begin
      hold_len <= scl_drive_n_o ? 9'h000 : hold_len + 9'h001;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_run_end;
    $fell(selftest_run_bit_i) ##0 pdb_s;
  endsequence

  sequence s_run_idle;
    !selftest_run_bit_i && pdb_s;
  endsequence

  chk_err_saturate: assert property (
    (err_cnt == dbac_pkg::ERROR_MAX && run_p && pdb_s) |=> (err_cnt == dbac_pkg::ERROR_MAX))
    else $error("error count wrapped past its ceiling");

  chk_err_frozen: assert property (
    s_run_end ##1 s_run_idle [*3] |-> $stable(err_cnt))
    else $error("error count moved after the run ended");

  chk_err_clear: assert property (
    ($rose(selftest_run_bit_i) || !pdb_s) |=> (err_cnt == 8'h00))
    else $error("error count not cleared");

  chk_stretch_len: assert property (
    $rose(scl_drive_n_o) |-> ($past(hold_len) + 9'h001 == $past(low_cyc, 2)))
    else $error("clock stretch length differs from low count");

  chk_fc_blocked: assert property (
    (audio[dbac_pkg::AUD_HOLD_BIT] && fc_load_i && !wr_en && pdb_s) |=> $stable(audio))
    else $error("forward load changed a held register");

  chk_aux_pins: assert property (
    audio[dbac_pkg::AUD_AUX_BIT] |=> (general_io_o == {$past(aux_word_select_i),
                                                      $past(aux_data_i)}))
    else $error("aux audio not on general io pins");

  chk_audio_off: assert property (
    audio[dbac_pkg::AUD_OFF_BIT] |=> (i2s_data_o == 4'h0))
    else $error("audio output active while disabled");

  chk_island_only: assert property (
    surround_o |-> !frame_transport_o)
    else $error("frame transport selected with surround");

  chk_reserved_zero: assert property (
    (audio & ~dbac_pkg::AUD_WR_MASK) == 8'h00)
    else $error("reserved audio bits set");

endmodule : dbac_regs

// >>> testbench/dbac_host_model.sv
// Control-bus host model on open-drain lines with pull-ups
module dbac_host_model (
  input  wire logic clk_i,
  input  wire logic scl_drive_n_i,
  input  wire logic sda_drive_n_i,
  output logic      scl_o,
  output logic      sda_o,
  output logic      hung_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_rel;
  logic sda_rel;

  assign scl_o = scl_rel & scl_drive_n_i;
  assign sda_o = sda_rel & sda_drive_n_i;

  initial
  begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    hung_o  = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  // A target may stretch the clock; the wait is bounded so a stuck line shows up
  task automatic rise();
    int n;
    n = 0;
    scl_rel <= 1'b1;
    @(posedge clk_i);
    while (scl_o !== 1'b1 && n < 1000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 1000)
      hung_o = 1'b1;
  endtask : rise

  // Data changes two cycles into the low phase so it never moves near an edge
  task automatic bit_xfer(input logic b, output logic r);
    wt(2);
    sda_rel <= b;
    wt(3);
    rise();
    wt(2);
    r = sda_o;
    scl_rel <= 1'b0;
  endtask : bit_xfer

  task automatic start();
    wt(5);
    rise();
    wt(3);
    sda_rel <= 1'b0;
    wt(3);
    scl_rel <= 1'b0;
  endtask : start

  task automatic stop();
    wt(2);
    sda_rel <= 1'b0;
    wt(3);
    rise();
    wt(3);
    sda_rel <= 1'b1;
    wt(3);
  endtask : stop

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : send

  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(last, r);
  endtask : recv
endmodule : dbac_host_model

// >>> testbench/tb.sv
// Self-checking bench for the audio and self-test register bank
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       power_down_bar   = 1'b1;
  logic       lrun  = 1'b0;
  logic       strun = 1'b0;
  logic       fce   = 1'b0;
  logic       fcl   = 1'b0;
  logic [7:0] fcd   = 8'h00;
  logic       rep   = 1'b0;
  logic       ibv   = 1'b0;
  logic       ibs   = 1'b0;
  logic       ftr   = 1'b1;
  logic [1:0] gpo   = 2'h1;
  logic       aws   = 1'b1;
  logic       adt   = 1'b0;
  logic [3:0] i2s   = 4'hA;
  wire        scl;
  wire        sda;
  wire        hung;
  logic       scl_dn;
  logic       sda_dn;
  logic       loc_dn;
  logic [1:0] gio;
  logic [3:0] i2s_o;
  logic       sur;
  logic       ftr_o;
  logic [9:0] run_len     = 10'h000;
  logic [9:0] stretch_len = 10'h000;
  logic [9:0] loc_len     = 10'h000;
  logic [9:0] hi_len      = 10'h000;
  logic [9:0] lo_len      = 10'h000;
  logic       prev_loc    = 1'b1;
  int         bad_count   = 0;
  int         check_count = 0;

  always #50 clk_i = ~clk_i;

  dbac_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .power_down_bar_i(power_down_bar), .scl_i(scl),
    .sda_i(sda), .scl_drive_n_o(scl_dn), .sda_drive_n_o(sda_dn), .local_master_run_i(lrun),
    .local_scl_drive_n_o(loc_dn), .selftest_run_bit_i(strun), .fc_error_i(fce),
    .fc_load_i(fcl), .fc_data_i(fcd), .repeater_i(rep), .inband_valid_i(ibv),
    .inband_surround_i(ibs), .frame_transport_i(ftr), .gpio_out_i(gpo),
    .aux_word_select_i(aws), .aux_data_i(adt), .i2s_data_i(i2s), .general_io_o(gio),
    .i2s_data_o(i2s_o), .surround_o(sur), .frame_transport_o(ftr_o));

  dbac_host_model host (.clk_i(clk_i), .scl_drive_n_i(scl_dn), .sda_drive_n_i(sda_dn),
    .scl_o(scl), .sda_o(sda), .hung_o(hung));

  // Run lengths of the stretch pull and of both local clock phases
  always @(posedge clk_i)
  begin
    if (scl_dn === 1'b0)
      run_len <= run_len + 10'h001;
    else if (run_len != 10'h000)
    begin
      stretch_len <= run_len;
      run_len     <= 10'h000;
    end
    if (loc_dn === prev_loc)
      loc_len <= loc_len + 10'h001;
    else
    begin
      if (prev_loc)
        hi_len <= loc_len;
      else
        lo_len <= loc_len;
      loc_len <= 10'h001;
    end
    prev_loc <= loc_dn;
  end

  function automatic logic [9:0] cyc(input logic [7:0] n);
    cyc = (10'(n) + 10'h001) >> 1;
    if (cyc == 10'h000)
      cyc = 10'h001;
  endfunction : cyc

  task automatic report_and_stop();
    if (hung === 1'b1)
      bad_count++;
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k0, k1, k2;
    host.start();
    host.send({dbac_pkg::TARGET_ADDR, 1'b0}, k0);
    host.send(a, k1);
    host.send(d, k2);
    host.stop();
    chk({7'h00, k0, k1, k2}, 10'h007);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic k0, k1, k2;
    logic [7:0] d;
    host.start();
    host.send({dbac_pkg::TARGET_ADDR, 1'b0}, k0);
    host.send(a, k1);
    host.start();
    host.send({dbac_pkg::TARGET_ADDR, 1'b1}, k2);
    host.recv(1'b1, d);
    host.stop();
    chk({7'h00, k0, k1, k2}, 10'h007);
    chk({2'b00, d}, {2'b00, e});
  endtask : rchk

  task automatic ochk(input logic [7:0] e);
    repeat (3) @(posedge clk_i);
    chk({2'b00, gio, i2s_o, sur, ftr_o}, {2'b00, e});
  endtask : ochk

  task automatic t_regs();
    logic k;
    rchk(dbac_pkg::OFS_ERROR_COUNT, 8'h00);
    rchk(dbac_pkg::OFS_HIGH_TIME, 8'h83);
    rchk(dbac_pkg::OFS_LOW_TIME, 8'h84);
    chk(stretch_len, cyc(8'h84));
    rchk(dbac_pkg::OFS_AUDIO, 8'h00);
    rchk(8'h30, 8'h00);
    wr(dbac_pkg::OFS_ERROR_COUNT, 8'h55);
    rchk(dbac_pkg::OFS_ERROR_COUNT, 8'h00);
    wr(dbac_pkg::OFS_AUDIO, 8'hFF);
    rchk(dbac_pkg::OFS_AUDIO, 8'h8D);
    wr(dbac_pkg::OFS_LOW_TIME, 8'h01);
    rchk(dbac_pkg::OFS_LOW_TIME, 8'h01);
    chk(stretch_len, cyc(8'h01));
    host.start();
    host.send({dbac_pkg::TARGET_ADDR ^ 7'h01, 1'b0}, k);
    host.stop();
    chk({9'h000, k}, 10'h000);
  endtask : t_regs

  task automatic t_bist();
    strun <= 1'b1;
    repeat (2) @(posedge clk_i);
    fce <= 1'b1;
    repeat (5) @(posedge clk_i);
    fce <= 1'b0;
    @(posedge clk_i);
    strun <= 1'b0;
    repeat (4) @(posedge clk_i);
    rchk(dbac_pkg::OFS_ERROR_COUNT, 8'h05);
    strun <= 1'b1;
    repeat (3) @(posedge clk_i);
    strun <= 1'b0;
    repeat (3) @(posedge clk_i);
    rchk(dbac_pkg::OFS_ERROR_COUNT, 8'h00);
    strun <= 1'b1;
    repeat (2) @(posedge clk_i);
    fce <= 1'b1;
    repeat (300) @(posedge clk_i);
    fce   <= 1'b0;
    strun <= 1'b0;
    repeat (3) @(posedge clk_i);
    rchk(dbac_pkg::OFS_ERROR_COUNT, 8'hFF);
    wr(dbac_pkg::OFS_HIGH_TIME, 8'h11);
    power_down_bar <= 1'b0;
    repeat (5) @(posedge clk_i);
    power_down_bar <= 1'b1;
    repeat (5) @(posedge clk_i);
    rchk(dbac_pkg::OFS_ERROR_COUNT, 8'h00);
    rchk(dbac_pkg::OFS_HIGH_TIME, 8'h83);
  endtask : t_bist

  task automatic t_local();
    wr(dbac_pkg::OFS_HIGH_TIME, 8'h07);
    wr(dbac_pkg::OFS_LOW_TIME, 8'h0A);
    lrun <= 1'b1;
    repeat (60) @(posedge clk_i);
    chk(hi_len, cyc(8'h07));
    chk(lo_len, cyc(8'h0A));
    lrun <= 1'b0;
    repeat (30) @(posedge clk_i);
    chk({9'h000, loc_dn}, 10'h001);
  endtask : t_local

  task automatic t_audio();
    wr(dbac_pkg::OFS_AUDIO, 8'h00);
    ochk({2'b01, 4'hA, 1'b0, 1'b1});
    wr(dbac_pkg::OFS_AUDIO, 8'h08);
    ochk({2'b10, 4'hA, 1'b0, 1'b1});
    wr(dbac_pkg::OFS_AUDIO, 8'h04);
    ochk({2'b01, 4'h0, 1'b0, 1'b1});
    wr(dbac_pkg::OFS_AUDIO, 8'h01);
    ochk({2'b01, 4'hA, 1'b1, 1'b0});
    rep <= 1'b1;
    ibv <= 1'b1;
    ochk({2'b01, 4'hA, 1'b0, 1'b1});
    wr(dbac_pkg::OFS_AUDIO, 8'h00);
    ibs <= 1'b1;
    ochk({2'b01, 4'hA, 1'b1, 1'b0});
    rep <= 1'b0;
    ibv <= 1'b0;
    ibs <= 1'b0;
    wr(dbac_pkg::OFS_AUDIO, 8'h00);
    fcd <= 8'hFF;
    fcl <= 1'b1;
    @(posedge clk_i);
    fcl <= 1'b0;
    rchk(dbac_pkg::OFS_AUDIO, 8'h0D);
    wr(dbac_pkg::OFS_AUDIO, 8'h80);
    fcl <= 1'b1;
    @(posedge clk_i);
    fcl <= 1'b0;
    rchk(dbac_pkg::OFS_AUDIO, 8'h80);
  endtask : t_audio

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_regs();
    t_bist();
    t_local();
    t_audio();
    report_and_stop();
  end

  // Whole sequence needs about 10000 cycles; six times that means a hang
  initial
  begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end
endmodule : tb
